//--- design/lbfc_regs.svh
`ifndef LBFC_REGS_SVH
`define LBFC_REGS_SVH
// Register byte offsets
`define LBFC_OFF_STAT_A 8'h00
`define LBFC_OFF_STAT_B 8'h04
`define LBFC_OFF_BOOST 8'h08
`define LBFC_OFF_SINK 8'h0C
`define LBFC_OFF_PUMP 8'h10
`define LBFC_OFF_SYS 8'h14
// fault_status_a bits
`define LBFC_SA_SEC 0
`define LBFC_SA_DISC 1
// boost_config fields
`define LBFC_BC_LIM 1:0
`define LBFC_BC_FSW 5:2
`define LBFC_BC_GAIN 8:6
// sink_config fields
`define LBFC_SC_FS 4:0
`define LBFC_SC_TRIM 8:5
// pump_config fields
`define LBFC_PC_DIV 1:0
`define LBFC_PC_DIV0 0
`define LBFC_PC_FIX 2
`define LBFC_PC_TRAN 3
// system_config fields
`define LBFC_SY_RST 0
`define LBFC_SY_SINK 15:8
// Reset values
`define LBFC_RST_BOOST 9'h188
`define LBFC_RST_SINK 9'h012
`define LBFC_RST_PUMP 4'h0
`define LBFC_RST_SINKS 8'h00
// Cycle limit codes
`define LBFC_LIM_1A 2'h0
// Brightness thresholds, 12-bit scale
`define LBFC_BR_50 12'h800
`define LBFC_BR_75 12'hC00
`endif

//--- design/lbfc_pkg.sv
package lbfc_pkg;
  // Charge-pump frequency ratio relative to boost switching
  typedef enum logic [1:0] {
    LBFC_CP_HALF = 2'b00,
    LBFC_CP_QUARTER = 2'b01,
    LBFC_CP_EIGHTH = 2'b10
  } lbfc_ratio_e;

  // Whole state of the controller
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] stat_a;
    logic [7:0] stat_b;
    logic [8:0] boost_cfg;
    logic [8:0] sink_cfg;
    logic [3:0] pump_cfg;
    logic [7:0] sinks_req;
    logic soft_rst;
    logic sec_latch;
    logic lowside_off;
    logic [7:0] excl;
    logic conv_en;
    logic [7:0] sink_en;
    logic cp_disc;
    logic [1:0] ilim;
    lbfc_ratio_e ratio;
  } lbfc_state_s;
endpackage

//--- design/lbfc_ctrl.sv
// Notes on behaviour
// - Open string at OVP: exclude, flag status_b
// - Exclusion holds until sinks off or reset
// - Cycle limit: low side off till cycle
// - Soft start forces the one ampere limit
// - Two-bit field picks four cycle limits
// - Secondary trip kills converter, sinks; flag
// - Secondary flag clears on status_a read
// - Secondary fault latched until shutdown/reset
// - Output drop: disconnect pump, pause sinks
// - Sinks return once output fault clears
// - Full-scale field resets to code 10010
// - Full scale is 2 mA plus code
// - Four-bit trim raises full scale slightly
// - Four-bit field selects boost frequency
// - Auto ratio: eighth, quarter, half by brightness
// - Fixed select: divider fixes the ratio
// - Transition bit: two ratios split at half
// - Three-bit field sets loop DC gain
// - All status bits clear on read
// - Enable low or reset bit clears faults
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "lbfc_regs.svh"

module lbfc_ctrl
  import lbfc_pkg::*;
(
  input wire logic pclk, // Bus clock, 40 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic en_pin, // Enable pin, low means shutdown
  input wire logic soft_start, // Converter in soft start
  input wire logic sw_cycle_start, // Pulse at each switching cycle
  input wire logic ocp_cycle, // Cycle-by-cycle limit reached
  input wire logic ocp_sec, // Secondary over-current comparator
  input wire logic out_drop, // Sudden output drop detector
  input wire logic ovp_trip, // Output over-voltage comparator
  input wire logic [7:0] string_underreg, // Per-string under-regulation
  input wire logic [11:0] bright_lvl, // Current brightness level
  output logic conv_en, // Boost and pump may switch
  output logic lowside_off, // Force boost low side off
  output logic [1:0] ilim_sel, // Applied cycle limit code
  output logic [3:0] fsw_sel, // Boost frequency code
  output logic [2:0] loop_gain_sel,
  output logic [4:0] full_scale_sel,
  output logic [3:0] full_scale_trim,
  output logic [1:0] pump_ratio,
  output logic cp_disconnect, // Open the pump output switch
  output logic [7:0] sink_en, // Per-string sink enable
  output logic [7:0] fb_exclude // Strings kept out of regulation
);

  // Reset image of the whole state
  localparam lbfc_state_s RST = '{
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
    stat_a: 2'h0, stat_b: 8'h00,
    boost_cfg: `LBFC_RST_BOOST, sink_cfg: `LBFC_RST_SINK,
    pump_cfg: `LBFC_RST_PUMP, sinks_req: `LBFC_RST_SINKS,
    soft_rst: 1'b0, sec_latch: 1'b0, lowside_off: 1'b0,
    excl: 8'h00, conv_en: 1'b0, sink_en: 8'h00,
    cp_disc: 1'b0, ilim: `LBFC_LIM_1A, ratio: LBFC_CP_EIGHTH};

  lbfc_state_s state_reg; // Registered state
  lbfc_state_s state_next; // Next state

  logic setup_rd; // First access cycle: capture read data
  logic done; // Completing edge of a transfer
  logic [7:0] open_set; // Strings newly found open
  logic [1:0] a_set; // New status_a events

  // Bus phase decode
  assign setup_rd = psel & penable & ~state_reg.pready;
  assign done = psel & penable & state_reg.pready;
  // Only enabled strings short of regulation count as open
  assign open_set = ovp_trip ? (string_underreg & state_reg.sinks_req) : 8'h00;
  assign a_set = {out_drop, ocp_sec};

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    // One wait cycle, then ready for one cycle
    // Read data is captured a cycle before pready so the address mux
    // stays out of the ready path; that costs the single wait state
    state_next.pready = setup_rd;
    if (setup_rd) begin
      state_next.pslverr = 1'b0;
      state_next.prdata = 32'h0000_0000;
      unique case (paddr)
        `LBFC_OFF_STAT_A: state_next.prdata[1:0] = state_reg.stat_a;
        `LBFC_OFF_STAT_B: state_next.prdata[7:0] = state_reg.stat_b;
        `LBFC_OFF_BOOST: state_next.prdata[8:0] = state_reg.boost_cfg;
        `LBFC_OFF_SINK: state_next.prdata[8:0] = state_reg.sink_cfg;
        `LBFC_OFF_PUMP: state_next.prdata[3:0] = state_reg.pump_cfg;
        `LBFC_OFF_SYS: begin
          state_next.prdata[`LBFC_SY_SINK] = state_reg.sinks_req;
          state_next.prdata[`LBFC_SY_RST] = state_reg.soft_rst;
        end
        // Unmapped address answers with an error
        default: state_next.pslverr = 1'b1;
      endcase
    end
    // A written one lives for exactly one cycle, long enough for the
    // shutdown branch at the bottom to see it
    // Reset bit clears itself after one cycle
    state_next.soft_rst = 1'b0;
    // Register writes at the completing edge
    if (done && pwrite) begin
      unique case (paddr)
        `LBFC_OFF_BOOST: state_next.boost_cfg = pwdata[8:0];
        `LBFC_OFF_SINK: state_next.sink_cfg = pwdata[8:0];
        `LBFC_OFF_PUMP: state_next.pump_cfg = pwdata[3:0];
        `LBFC_OFF_SYS: begin
          state_next.sinks_req = pwdata[`LBFC_SY_SINK];
          state_next.soft_rst = pwdata[`LBFC_SY_RST];
        end
        // Status registers are read-only; others ignored
        default: ;
      endcase
    end
    // Read-clear drops only bits that were returned; new events win
    if (done && !pwrite && paddr == `LBFC_OFF_STAT_A) begin
      state_next.stat_a = state_reg.stat_a & ~state_reg.prdata[1:0];
    end
    if (done && !pwrite && paddr == `LBFC_OFF_STAT_B) begin
      state_next.stat_b = state_reg.stat_b & ~state_reg.prdata[7:0];
    end
    state_next.stat_a = state_next.stat_a | a_set;
    state_next.stat_b = state_next.stat_b | open_set;
    // Secondary fault latches the converter off
    // Only shutdown or the reset bit lowers it; reading the flag does
    // not restart the converter
    state_next.sec_latch = state_reg.sec_latch | ocp_sec;
    // Low side held off to the next cycle start; a new trip wins
    // The trip is a level, so a comparator still high at the cycle
    // start keeps the switch off for that cycle as well
    if (sw_cycle_start) begin
      state_next.lowside_off = 1'b0;
    end
    if (ocp_cycle) begin
      state_next.lowside_off = 1'b1;
    end
    // Exclusion sticks through reconnection; freed when all sinks off
    // Limitation: strings are freed only all together, never one by one
    if (state_reg.sinks_req == 8'h00) begin
      state_next.excl = 8'h00;
    end
    state_next.excl = state_next.excl | open_set;
    // Drop opens the pump switch only while the fault stands
    // No debounce: a chattering detector toggles the switch with it
    state_next.cp_disc = out_drop;
    // Boost keeps switching through a drop, stops on a latch
    state_next.conv_en = ~state_next.sec_latch;
    if (state_next.sec_latch || out_drop) begin
      state_next.sink_en = 8'h00;
    end else begin
      state_next.sink_en = state_next.sinks_req;
    end
    // Soft start overrides the programmed limit
    // The programmed code returns on the edge after soft start falls,
    // so the first cycle without soft start still sees the one ampere limit
    if (soft_start) begin
      state_next.ilim = `LBFC_LIM_1A;
    end else begin
      state_next.ilim = state_reg.boost_cfg[`LBFC_BC_LIM];
    end
    // Charge-pump ratio selection
    // Recomputed every cycle so a brightness move acts at once; the
    // pump side must accept a ratio change in the middle of a cycle
    if (state_reg.pump_cfg[`LBFC_PC_TRAN]) begin
      if (state_reg.pump_cfg[`LBFC_PC_DIV0]) begin
        state_next.ratio = (bright_lvl >= `LBFC_BR_50) ? LBFC_CP_QUARTER
                                                       : LBFC_CP_EIGHTH;
      end else begin
        state_next.ratio = (bright_lvl >= `LBFC_BR_50) ? LBFC_CP_HALF
                                                       : LBFC_CP_QUARTER;
      end
    end else if (state_reg.pump_cfg[`LBFC_PC_FIX]) begin
      unique case (state_reg.pump_cfg[`LBFC_PC_DIV])
        2'b00: state_next.ratio = LBFC_CP_HALF;
        2'b01: state_next.ratio = LBFC_CP_QUARTER;
        default: state_next.ratio = LBFC_CP_EIGHTH;
      endcase
    end else if (bright_lvl >= `LBFC_BR_75) begin
      state_next.ratio = LBFC_CP_HALF;
    end else if (bright_lvl >= `LBFC_BR_50) begin
      state_next.ratio = LBFC_CP_QUARTER;
    end else begin
      state_next.ratio = LBFC_CP_EIGHTH;
    end
    // Shutdown or reset bit: registers and latches back to reset,
    // bus handshake kept so an open transfer still completes
    if (!en_pin || state_reg.soft_rst) begin
      state_next = RST;
      state_next.pready = setup_rd;
      state_next.pslverr = setup_rd ? state_next.pslverr : state_reg.pslverr;
      state_next.prdata = state_reg.prdata;
      if (setup_rd) begin
        state_next.pslverr = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  // Frequency, gain and full-scale fields leave straight from the config flops, so a write
  // reaches the analog side right after its completing edge
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign conv_en = state_reg.conv_en;
  assign lowside_off = state_reg.lowside_off;
  assign ilim_sel = state_reg.ilim;
  assign fsw_sel = state_reg.boost_cfg[`LBFC_BC_FSW];
  assign loop_gain_sel = state_reg.boost_cfg[`LBFC_BC_GAIN];
  assign full_scale_sel = state_reg.sink_cfg[`LBFC_SC_FS];
  assign full_scale_trim = state_reg.sink_cfg[`LBFC_SC_TRIM];
  assign pump_ratio = state_reg.ratio;
  assign cp_disconnect = state_reg.cp_disc;
  assign sink_en = state_reg.sink_en;
  assign fb_exclude = state_reg.excl;

  // Checks
  // Most hold only while no shutdown acts; the shutdown branch
  // overrides all but the bus handshake and is watched by checks of its own
  logic live; // No shutdown acting this cycle
  assign live = en_pin & ~state_reg.soft_rst;

  // A drop while the converter runs, with no secondary trip beside it
  sequence s_drop;
    out_drop && live && !ocp_sec && conv_en;
  endsequence

  sequence s_drop_gone;
    cp_disconnect && !out_drop && live && !state_reg.sec_latch && !ocp_sec;
  endsequence

  a_sec_trip_off: assert property (@(posedge pclk) disable iff (!presetn)
    ocp_sec && live |=> !conv_en && sink_en == 8'h00 && state_reg.stat_a[0])
    else $error("secondary trip did not stop converter");

  a_sec_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.sec_latch && live |=> state_reg.sec_latch && !conv_en)
    else $error("secondary latch released early");

  a_cycle_lim_off: assert property (@(posedge pclk) disable iff (!presetn)
    ocp_cycle && live |=> lowside_off)
    else $error("low side not forced off");

  a_cycle_lim_hold: assert property (@(posedge pclk) disable iff (!presetn)
    lowside_off && !sw_cycle_start && live |=> lowside_off)
    else $error("low side released before cycle start");

  a_drop_disc: assert property (@(posedge pclk) disable iff (!presetn)
    s_drop |=> cp_disconnect && sink_en == 8'h00 && conv_en)
    else $error("output drop not handled");

  a_drop_recover: assert property (@(posedge pclk) disable iff (!presetn)
    s_drop_gone |=> !cp_disconnect && sink_en == state_reg.sinks_req)
    else $error("sinks not restored after drop");

  a_soft_lim: assert property (@(posedge pclk) disable iff (!presetn)
    soft_start && live |=> ilim_sel == `LBFC_LIM_1A)
    else $error("soft start limit not applied");

  a_excl_hold: assert property (@(posedge pclk) disable iff (!presetn)
    live && state_reg.sinks_req != 8'h00 |=> (fb_exclude & $past(fb_exclude)) == $past(fb_exclude))
    else $error("excluded string readmitted");

  a_open_flag: assert property (@(posedge pclk) disable iff (!presetn)
    live && open_set != 8'h00 |=> (fb_exclude & $past(open_set)) == $past(open_set)
      && (state_reg.stat_b & $past(open_set)) == $past(open_set))
    else $error("open string not excluded");

  a_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && paddr == `LBFC_OFF_STAT_A && a_set == 2'h0 && live
      |=> state_reg.stat_a == ($past(state_reg.stat_a) & ~$past(prdata[1:0])))
    else $error("status not cleared on read");

  a_pump_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    live && state_reg.pump_cfg == 4'h4 |=> pump_ratio == LBFC_CP_HALF)
    else $error("fixed pump ratio wrong");

  a_rst_bit: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.soft_rst |=> !state_reg.soft_rst && !state_reg.sec_latch
      && full_scale_sel == 5'h12)
    else $error("reset bit did not clear state");

  // Steps of a cycle-limit release and of a pin shutdown
  sequence s_lim_release;
    lowside_off && sw_cycle_start && !ocp_cycle && live;
  endsequence

  sequence s_pin_off;
    !en_pin;
  endsequence

  a_cycle_lim_free: assert property (@(posedge pclk) disable iff (!presetn)
    s_lim_release |=> !lowside_off)
    else $error("low side not released at cycle start");

  a_pin_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
    s_pin_off |=> !conv_en && sink_en == 8'h00 && !state_reg.sec_latch)
    else $error("enable pin low did not shut down");

  a_latch_sinks: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.sec_latch && live |=> sink_en == 8'h00)
    else $error("sinks enabled during secondary latch");

  a_lim_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !soft_start && live |=> ilim_sel == $past(state_reg.boost_cfg[`LBFC_BC_LIM]))
    else $error("applied limit differs from field");

  a_drop_flag: assert property (@(posedge pclk) disable iff (!presetn)
    out_drop && live |=> state_reg.stat_a[`LBFC_SA_DISC])
    else $error("disconnect flag not set");

  // Read-clear drops each flag that the read returned
  a_sec_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && paddr == `LBFC_OFF_STAT_A && !ocp_sec && live
      && prdata[`LBFC_SA_SEC] |=> !state_reg.stat_a[`LBFC_SA_SEC])
    else $error("secondary flag not cleared by read");

  a_open_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pwrite && paddr == `LBFC_OFF_STAT_B && open_set == 8'h00 && live
      |=> (state_reg.stat_b & $past(prdata[7:0])) == 8'h00)
    else $error("open flags not cleared by read");

  a_excl_free: assert property (@(posedge pclk) disable iff (!presetn)
    live && state_reg.sinks_req == 8'h00 |=> fb_exclude == 8'h00)
    else $error("exclusion kept with all sinks off");

  // Pump ratio in each mode at brightness corners
  a_auto_high: assert property (@(posedge pclk) disable iff (!presetn)
    live && !state_reg.pump_cfg[`LBFC_PC_TRAN] && !state_reg.pump_cfg[`LBFC_PC_FIX]
      && bright_lvl >= `LBFC_BR_75 |=> pump_ratio == LBFC_CP_HALF)
    else $error("auto ratio wrong at high brightness");

  a_auto_low: assert property (@(posedge pclk) disable iff (!presetn)
    live && !state_reg.pump_cfg[`LBFC_PC_TRAN] && !state_reg.pump_cfg[`LBFC_PC_FIX]
      && bright_lvl < `LBFC_BR_50 |=> pump_ratio == LBFC_CP_EIGHTH)
    else $error("auto ratio wrong at low brightness");

  a_tran_low: assert property (@(posedge pclk) disable iff (!presetn)
    live && state_reg.pump_cfg[`LBFC_PC_TRAN] && !state_reg.pump_cfg[`LBFC_PC_DIV0]
      && bright_lvl < `LBFC_BR_50 |=> pump_ratio == LBFC_CP_QUARTER)
    else $error("transition ratio wrong below half");

  a_tran_high: assert property (@(posedge pclk) disable iff (!presetn)
    live && state_reg.pump_cfg[`LBFC_PC_TRAN] && state_reg.pump_cfg[`LBFC_PC_DIV0]
      && bright_lvl >= `LBFC_BR_50 |=> pump_ratio == LBFC_CP_QUARTER)
    else $error("transition ratio wrong above half");

  a_fixed_eighth: assert property (@(posedge pclk) disable iff (!presetn)
    live && !state_reg.pump_cfg[`LBFC_PC_TRAN] && state_reg.pump_cfg[`LBFC_PC_FIX]
      && state_reg.pump_cfg[`LBFC_PC_DIV] >= 2'h2 |=> pump_ratio == LBFC_CP_EIGHTH)
    else $error("fixed eighth ratio wrong");

endmodule // lbfc_ctrl

//--- tb/lbfc_ctrl_tb.sv
`timescale 1ns/1ps
`include "lbfc_regs.svh"

// Compare two values, count the check and report a mismatch at once
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module lbfc_ctrl_tb import lbfc_pkg::*;;
  logic pclk = 1'b0; // 40 MHz bus clock
  logic presetn = 1'b0; // Active-low reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic en_pin = 1'b1, soft_start = 1'b0, sw_cycle_start = 1'b0, ocp_cycle = 1'b0;
  logic ocp_sec = 1'b0, out_drop = 1'b0, ovp_trip = 1'b0;
  logic [7:0] string_underreg = 8'h00;
  logic [11:0] bright_lvl = 12'h000;
  logic conv_en, lowside_off, cp_disconnect;
  logic [1:0] ilim_sel, pump_ratio;
  logic [3:0] fsw_sel, full_scale_trim;
  logic [2:0] loop_gain_sel;
  logic [4:0] full_scale_sel;
  logic [7:0] sink_en, fb_exclude;
  int fail_count = 0; // Mismatches seen
  int num_checks = 0; // Comparisons made
  logic [31:0] lfsr = 32'h5309; // Random source, fixed start
  logic [31:0] rd, r;
  logic err;
  logic [11:0] br_tab [5] = '{12'h7FF, 12'h800, 12'hBFF, 12'hC00, 12'h000};

  // Half period of 12.5 ns
  always #12.5 pclk = ~pclk;

  lbfc_ctrl lbfc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .en_pin(en_pin), .soft_start(soft_start),
    .sw_cycle_start(sw_cycle_start), .ocp_cycle(ocp_cycle), .ocp_sec(ocp_sec),
    .out_drop(out_drop), .ovp_trip(ovp_trip), .string_underreg(string_underreg),
    .bright_lvl(bright_lvl), .conv_en(conv_en), .lowside_off(lowside_off),
    .ilim_sel(ilim_sel), .fsw_sel(fsw_sel), .loop_gain_sel(loop_gain_sel),
    .full_scale_sel(full_scale_sel), .full_scale_trim(full_scale_trim),
    .pump_ratio(pump_ratio), .cp_disconnect(cp_disconnect), .sink_en(sink_en),
    .fb_exclude(fb_exclude));

  // Fibonacci step; a new value per call keeps the run repeatable
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Expected pump ratio from the mode bits and brightness
  function automatic logic [1:0] exp_ratio(input logic [3:0] c, input logic [11:0] b);
    if (c[`LBFC_PC_TRAN]) begin
      if (b < `LBFC_BR_50) return c[0] ? LBFC_CP_EIGHTH : LBFC_CP_QUARTER;
      return c[0] ? LBFC_CP_QUARTER : LBFC_CP_HALF;
    end
    if (c[`LBFC_PC_FIX]) begin
      if (c[1:0] == 2'h0) return LBFC_CP_HALF;
      return (c[1:0] == 2'h1) ? LBFC_CP_QUARTER : LBFC_CP_EIGHTH;
    end
    if (b < `LBFC_BR_50) return LBFC_CP_EIGHTH;
    return (b < `LBFC_BR_75) ? LBFC_CP_QUARTER : LBFC_CP_HALF;
  endfunction

  // Verdict and end of run, the only exit
  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Let n rising edges land, then look at settled outputs
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // One APB transfer; pready is sampled at each rising edge, and the edge
  // that sees it high completes the transfer and hands over the read data
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin fail_count++; wrap_up(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Read and compare data and error response
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(err, ee)
  endtask

  initial begin
    step(1);
    // Outputs held at reset values while reset is low
    `CHK(full_scale_sel, 5'h12)
    `CHK(fsw_sel, 4'h2)
    `CHK(loop_gain_sel, 3'h6)
    repeat (11) @(posedge pclk);
    presetn <= 1'b1;
    // Register reset values and the unmapped hole
    rchk(`LBFC_OFF_BOOST, 32'h188, 1'b0);
    rchk(`LBFC_OFF_SINK, 32'h012, 1'b0);
    rchk(`LBFC_OFF_PUMP, 32'h0, 1'b0);
    rchk(`LBFC_OFF_SYS, 32'h0, 1'b0);
    rchk(8'h18, 32'h0, 1'b1);
    `CHK(conv_en, 1'b1)
    // Config fields, boundary frequency codes first, never the reserved ones
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      r[5:2] = (i == 0) ? 4'h2 : (i == 1) ? 4'hF : 4'h2 + 4'(r[5:2] % 14);
      apb(1'b1, `LBFC_OFF_BOOST, {23'h0, r[8:0]});
      apb(1'b1, `LBFC_OFF_SINK, {23'h0, r[17:9]});
      step(1);
      `CHK(fsw_sel, r[5:2])
      `CHK(loop_gain_sel, r[8:6])
      `CHK(ilim_sel, r[1:0])
      `CHK(full_scale_sel, r[13:9])
      `CHK(full_scale_trim, r[17:14])
    end
    // Soft start overrides the highest programmed limit
    apb(1'b1, `LBFC_OFF_BOOST, 32'h18B);
    soft_start <= 1'b1;
    step(2);
    `CHK(ilim_sel, `LBFC_LIM_1A)
    @(posedge pclk);
    soft_start <= 1'b0;
    step(2);
    `CHK(ilim_sel, 2'h3)
    // Every pump mode against brightness corners and a random level
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, `LBFC_OFF_PUMP, 32'(c));
      for (int b = 0; b < 5; b++) begin
        @(posedge pclk);
        bright_lvl <= (b == 4) ? 12'(rnd()) : br_tab[b];
        step(2);
        `CHK(pump_ratio, exp_ratio(4'(c), bright_lvl))
      end
    end
    // Cycle limit holds the low side off until the next cycle begins
    @(posedge pclk);
    ocp_cycle <= 1'b1;
    @(posedge pclk);
    ocp_cycle <= 1'b0;
    step(3);
    `CHK(lowside_off, 1'b1)
    @(posedge pclk);
    sw_cycle_start <= 1'b1;
    @(posedge pclk);
    sw_cycle_start <= 1'b0;
    step(2);
    `CHK(lowside_off, 1'b0)
    rchk(`LBFC_OFF_STAT_A, 32'h0, 1'b0);
    rchk(`LBFC_OFF_STAT_B, 32'h0, 1'b0);
    // Open string at the over-voltage trip, then reconnection
    apb(1'b1, `LBFC_OFF_SYS, 32'hFF00);
    string_underreg <= 8'h05;
    ovp_trip <= 1'b1;
    @(posedge pclk);
    ovp_trip <= 1'b0;
    string_underreg <= 8'h00;
    step(2);
    `CHK(fb_exclude, 8'h05)
    `CHK(sink_en, 8'hFF)
    rchk(`LBFC_OFF_STAT_B, 32'h05, 1'b0);
    rchk(`LBFC_OFF_STAT_B, 32'h0, 1'b0);
    `CHK(fb_exclude, 8'h05)
    apb(1'b1, `LBFC_OFF_SYS, 32'h0);
    step(1);
    `CHK(fb_exclude, 8'h00)
    apb(1'b1, `LBFC_OFF_SYS, 32'hFF00);
    // Output drop pauses the sinks and opens the pump output
    out_drop <= 1'b1;
    step(2);
    `CHK(cp_disconnect, 1'b1)
    `CHK(sink_en, 8'h00)
    `CHK(conv_en, 1'b1)
    @(posedge pclk);
    out_drop <= 1'b0;
    step(2);
    `CHK(sink_en, 8'hFF)
    `CHK(cp_disconnect, 1'b0)
    rchk(`LBFC_OFF_STAT_A, 32'h2, 1'b0);
    // Secondary trip latches the converter and sinks off
    ocp_sec <= 1'b1;
    @(posedge pclk);
    ocp_sec <= 1'b0;
    step(2);
    `CHK(conv_en, 1'b0)
    `CHK(sink_en, 8'h00)
    rchk(`LBFC_OFF_STAT_A, 32'h1, 1'b0);
    rchk(`LBFC_OFF_STAT_A, 32'h0, 1'b0);
    step(4);
    `CHK(conv_en, 1'b0)
    // Self-clearing reset bit releases the latch and clears registers
    apb(1'b1, `LBFC_OFF_SYS, 32'hFF01);
    step(2);
    `CHK(conv_en, 1'b1)
    rchk(`LBFC_OFF_SYS, 32'h0, 1'b0);
    // Enable pin shutdown also restores reset values
    apb(1'b1, `LBFC_OFF_SINK, 32'h1FF);
    ocp_sec <= 1'b1;
    @(posedge pclk);
    ocp_sec <= 1'b0;
    en_pin <= 1'b0;
    step(2);
    @(posedge pclk);
    en_pin <= 1'b1;
    step(2);
    `CHK(conv_en, 1'b1)
    `CHK(full_scale_sel, 5'h12)
    rchk(`LBFC_OFF_SINK, 32'h012, 1'b0);
    wrap_up();
  end
endmodule // lbfc_ctrl_tb
